// >>> hw/prog_check_map.svh
// constants for the flash program result checker
`ifndef PROG_CHECK_MAP_SVH
`define PROG_CHECK_MAP_SVH
`define PC_BIT_UNUSED_HI   7
`define PC_BIT_MODE        6
`define PC_BIT_EXEC        5
`define PC_BIT_KEY         4
`define PC_BIT_UNUSED_LO   3
`define PC_BIT_DATA        2
`define PC_BIT_DEST        1
`define PC_BIT_FAIL        0
`define PC_CNT_LAST        8'h01
`define PC_CNT_CLEAR       8'h00
`define PC_ADDR_CLEAR      32'h0000_0000
`define PC_KEY_OK          8'h5A
`define PC_MAT_USER_BOOT   8'hAA
`define PC_ALIGN_LO        8'h00
`define PC_ALIGN_HI        8'h80
`define PC_STATUS_RESET    8'h00
`define PC_FLASH_BASE      32'h0000_0000
`define PC_FLASH_LIMIT     32'h0001_FFFF
`define PC_PROG_CYCLES     8'h04
`endif

// >>> hw/prog_check_pkg.sv
// types for the flash program result checker
package prog_check_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_DONE = 2'b10
  } pc_state_t;

  typedef struct packed {
    logic [31:0] dest_addr;
    logic [31:0] data_addr;
  } prog_req_t;
endpackage

// >>> hw/flash_program_result_checker.sv
// flash programming request checker and pass/fail status word
// Contract
// R1: mode error bit 6 set when enable pin low or protection active.
// R2: execution error bit 5 set when destination was not erased.
// R3: execution error when array select holds AA (user boot array).
// R4: refused boot-array request writes neither array.
// R5: key error bit 4 set unless key register holds 5A.
// R6: data address error bit 2 set when source lies inside flash.
// R7: destination error bit 1 set when destination outside flash.
// R8: destination error also set when low byte not 00 or 80.
// R9: success/fail bit 0 set on any error, clear on normal end.
// R10: caller erases the array after an execution error before retrying.
// R11: caller programs the boot array only via boot or programmer mode.
// R12: unused status bits 7 and 3 always read zero.
`timescale 1ns/1ps
`include "prog_check_map.svh"
module flash_program_result_checker
  import prog_check_pkg::*;
#(
  parameter logic [31:0] FLASH_BASE  = `PC_FLASH_BASE,
  parameter logic [31:0] FLASH_LIMIT = `PC_FLASH_LIMIT,
  parameter logic [7:0]  PROG_CYCLES = `PC_PROG_CYCLES
)
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire prog_req_t  req,
  input  wire logic       program_enable_pin,
  input  wire logic       protection_error_flag,
  input  wire logic [7:0] program_key_reg,
  input  wire logic [7:0] memory_array_select_reg,
  input  wire logic       dest_not_erased,
  output logic            busy,
  output logic            done,
  output logic            prog_write_en,
  output logic [31:0]     prog_write_addr,
  output logic [7:0]      program_result_status
);
  // parameters the logic cannot serve are refused at elaboration
  if (FLASH_LIMIT < FLASH_BASE)
  begin : g_bad_range
    $error("flash_program_result_checker: flash limit below base");
  end

  if (PROG_CYCLES == `PC_CNT_CLEAR)
  begin : g_bad_cycles
    $error("flash_program_result_checker: zero program cycles");
  end

  function automatic logic in_flash(input logic [31:0] a);
    in_flash = (a >= FLASH_BASE) && (a <= FLASH_LIMIT);
  endfunction

  // low byte must sit on a 128-byte boundary
  function automatic logic misaligned(input logic [31:0] a);
    misaligned = (a[7:0] != `PC_ALIGN_LO) && (a[7:0] != `PC_ALIGN_HI);
  endfunction

  pc_state_t   state_r;
  pc_state_t   state_nxt;
  logic [7:0]  status_r;
  logic [7:0]  status_nxt;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic [31:0] waddr_r;
  logic [31:0] waddr_nxt;
  logic        done_r;
  logic        done_nxt;
  logic [7:0]  chk;
  logic        take;
  logic        in_prog;

  // checks sampled at the start strobe; an error skips programming entirely
  always_comb
  begin
    chk = `PC_STATUS_RESET;
    chk[`PC_BIT_MODE] = !program_enable_pin || protection_error_flag; // R1
    chk[`PC_BIT_EXEC] = (memory_array_select_reg == `PC_MAT_USER_BOOT); // R3
    chk[`PC_BIT_KEY]  = (program_key_reg != `PC_KEY_OK); // R5
    chk[`PC_BIT_DATA] = in_flash(req.data_addr); // R6
    chk[`PC_BIT_DEST] = !in_flash(req.dest_addr) // R7
                        || misaligned(req.dest_addr); // R8
    chk[`PC_BIT_FAIL] = |chk[`PC_BIT_MODE:`PC_BIT_DEST]; // R9
  end

  // start while busy is ignored, so a request is never half taken
  assign take    = start && (state_r == ST_IDLE);
  assign in_prog = (state_r == ST_PROG);

  // sequencing
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        // refused requests never reach the write strobe
        if (take)
          state_nxt = chk[`PC_BIT_FAIL] ? ST_DONE : ST_PROG; // R4
      end
      ST_PROG:
      begin
        // unerased destination is only known once writing is underway
        if (dest_not_erased || (cnt_r == `PC_CNT_LAST))
          state_nxt = ST_DONE;
      end
      ST_DONE:
      begin
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // completion pulse
  always_comb
  begin
    done_nxt = (state_r == ST_DONE);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      done_r <= 1'b0;
    else
      done_r <= done_nxt;
  end

  // status word; kept until the next accepted start
  always_comb
  begin
    status_nxt = status_r;
    if (take)
      status_nxt = chk;
    else if (in_prog && dest_not_erased)
    begin
      status_nxt[`PC_BIT_EXEC] = 1'b1; // R2
      status_nxt[`PC_BIT_FAIL] = 1'b1; // R9
    end
    status_nxt[`PC_BIT_UNUSED_HI] = 1'b0; // R12
    status_nxt[`PC_BIT_UNUSED_LO] = 1'b0; // R12
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      status_r <= `PC_STATUS_RESET;
    else
      status_r <= status_nxt;
  end

  // programming cycle counter
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (take)
      cnt_nxt = PROG_CYCLES;
    else if (in_prog && (cnt_r != `PC_CNT_LAST))
      cnt_nxt = cnt_r - `PC_CNT_LAST;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cnt_r <= `PC_CNT_CLEAR;
    else
      cnt_r <= cnt_nxt;
  end

  // destination address, latched even for refused requests
  always_comb
  begin
    waddr_nxt = waddr_r;
    if (take)
      waddr_nxt = req.dest_addr;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      waddr_r <= `PC_ADDR_CLEAR;
    else
      waddr_r <= waddr_nxt;
  end

  assign busy                  = (state_r != ST_IDLE);
  assign done                  = done_r;
  assign prog_write_en         = in_prog; // R4
  assign prog_write_addr       = waddr_r;
  assign program_result_status = status_r;
endmodule

// >>> verif/fprc_chk.sv
// port assertions for the program result checker
`timescale 1ns/1ps
module fprc_chk
  import prog_check_pkg::*;
(
  input logic       core_clk,
  input logic       rst,
  input prog_req_t  req,
  input logic       program_enable_pin,
  input logic       protection_error_flag,
  input logic [7:0] program_key_reg,
  input logic [7:0] memory_array_select_reg,
  input logic       dest_not_erased,
  input logic       busy,
  input logic       done,
  input logic       prog_write_en,
  input logic [7:0] program_result_status
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [7:0] st = program_result_status;
  wire       boot = memory_array_select_reg == 8'hAA;
  a_mode_bit: assert property ($rose(busy) |-> st[6] ==
    (!program_enable_pin || protection_error_flag)) else $error("mode bit");
  a_exec_bit: assert property (prog_write_en && dest_not_erased |=> st[5] && st[0])
    else $error("exec bit");
  a_boot_refused: assert property ($rose(busy) && boot |-> st[5] ##0 (!prog_write_en)[*2])
    else $error("boot refuse");
  a_key_bit: assert property ($rose(busy) |-> st[4] == (program_key_reg != 8'h5A))
    else $error("key bit");
  a_data_bit: assert property ($rose(busy) |-> st[2] == (req.data_addr < 32'h0002_0000))
    else $error("data bit");
  a_dest_bit: assert property ($rose(busy) |-> st[1] == (req.dest_addr > 32'h0001_FFFF
    || !(req.dest_addr[7:0] inside {8'h00, 8'h80}))) else $error("dest bit");
  a_fail_sum: assert property (done |-> st[0] == |{st[6:4], st[2:1]}) else $error("fail bit");
  a_unused_zero: assert property (!st[7] && !st[3]) else $error("unused bits");
  c_refused: cover property ($rose(busy) && boot);
  c_unerased: cover property (prog_write_en && dest_not_erased);
  c_passed: cover property (done && st == 8'h00);
endmodule
bind flash_program_result_checker fprc_chk i_chk (.*);

// >>> verif/cpu_req_model.sv
// processor side: one start strobe per request, never while busy
`timescale 1ns/1ps
module cpu_req_model
(
  input  wire logic core_clk,
  input  wire logic go,
  input  wire logic busy,
  output logic      start = 1'b0
);
  always @(posedge core_clk) start <= go && !busy && !start;
endmodule

// >>> verif/flash_program_result_checker_tb.sv
// self-checking bench for the program result checker
`timescale 1ns/1ps
module flash_program_result_checker_tb
  import prog_check_pkg::*;
;
  logic       core_clk = 0, rst = 1, go = 0, pin = 1, prot = 0, ne = 0, start, busy, done;
  logic [7:0] key = 8'h5A, mat = 8'h00, st;
  logic        wen;
  logic [31:0] wad;
  prog_req_t  req = '0;
  int         err_total = 0, tests_run = 0;
  flash_program_result_checker i_dut (.core_clk, .rst, .start, .req, .program_enable_pin(pin),
    .protection_error_flag(prot), .program_key_reg(key), .memory_array_select_reg(mat),
    .dest_not_erased(ne), .busy, .done, .prog_write_en(wen), .prog_write_addr(wad),
    .program_result_status(st));
  cpu_req_model i_cpu (.core_clk, .go, .busy, .start);
  initial forever #20 core_clk = ~core_clk;
  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check_status(logic [7:0] e);
    tests_run++;
    if ({done, busy, st} !== {2'b10, e})
    begin
      err_total++;
      $display("[ERR] status exp %h got done %b busy %b %h", e, done, busy, st);
    end
  endtask
  task automatic check_writes(int exp, int got);
    tests_run++;
    if (exp != got)
    begin
      err_total++;
      $display("[ERR] write cycles exp %0d got %0d", exp, got);
    end
  endtask
  task automatic check_addr(logic [31:0] exp);
    tests_run++;
    if (wad !== exp)
    begin
      err_total++;
      $display("[ERR] write address exp %h got %h", exp, wad);
    end
  endtask
  // boot array is selected only to see it refused
  task automatic run(logic p = 1'b1, f = 1'b0, n = 1'b0, logic [7:0] k = 8'h5A, m = 8'h00,
                     logic [31:0] d = 32'h0000_0100, s = 32'h0002_0000);
    logic [7:0] e;
    int         w;
    w = 0;
    e = {1'b0, !p || f, 1'b0, k != 8'h5A, 1'b0, s < 32'h0002_0000,
         d > 32'h0001_FFFF || !(d[7:0] inside {8'h00, 8'h80}), 1'b0};
    e[5] = m == 8'hAA || (n && e == 8'h00);
    e[0] = e != 8'h00;
    @(posedge core_clk);
    {pin, prot, ne, key, mat, req, go} <= {p, f, n, k, m, d, s, 1'b1};
    @(posedge core_clk);
    go <= 1'b0;
    for (int i = 0; i < 12 && done !== 1'b1; i++)
    begin
      @(posedge core_clk) #1;
      w += (wen === 1'b1);
    end
    check_status(e);
    check_writes((e == 8'h00) ? 4 : (e[5] && m != 8'hAA) ? 1 : 0, w);
    check_addr(d);
    $display("test ended");
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    run();
    run(.p(1'b0));
    run(.f(1'b1));
    run(.k(8'h5B));
    run(.m(8'hAA));
    run(.s(32'h0001_FFFF));
    run(.d(32'h0002_0000));
    run(.d(32'h0000_0140));
    run(.d(32'h0000_0180));
    run(.n(1'b1));
    run();
    complete_run;
  end
  initial
  begin
    #20000;
    err_total++;
    complete_run;
  end
endmodule
